//--- rtl/tbcio_chan.sv
// pin and capture logic of one channel's b general register
`include "tbcio_consts.svh"

module tbcio_chan #(
  parameter int CHAN = 1
) (
  input  wire logic      clk,
  input  wire logic      rst_b,
  tbcio_chan_if.chan     ch
);

  tbcio_pkg::tbcio_chan_state_t s_reg;
  tbcio_pkg::tbcio_chan_state_t s_next;

  logic       is_cap;
  logic       cmp_en;
  logic       int_src;
  logic       rise;
  logic       fall;
  logic       pin_hit;
  logic [1:0] low2;

  // mode decode of the field
  assign is_cap  = ch.field[`TBCIO_F_CAP];                              // [R1] [R3]
  assign low2    = ch.field[`TBCIO_F_BOTH:`TBCIO_F_FALL];
  assign cmp_en  = !is_cap && (low2 != `TBCIO_ACT_OFF);                 // [R1]
  assign int_src = (CHAN != 2) && ch.field[`TBCIO_F_SRC];               // [R4] [R7]
  assign rise    = ch.pin_in && !s_reg.pin_prev;
  assign fall    = !ch.pin_in && s_reg.pin_prev;

  // edge selection for pin-sourced capture
  always_comb begin
    if (ch.field[`TBCIO_F_BOTH]) begin
      pin_hit = rise || fall;                                           // [R3]
    end else if (ch.field[`TBCIO_F_FALL]) begin
      pin_hit = fall;                                                   // [R3]
    end else begin
      pin_hit = rise;                                                   // [R3]
    end
  end

  // next state: pin level on load or match, capture strobe
  always_comb begin
    s_next          = s_reg;
    s_next.pin_prev = ch.pin_in;
    s_next.cap      = 1'b0;
    if (!is_cap) begin
      if (ch.load && cmp_en) begin
        s_next.lvl = ch.field[`TBCIO_F_SRC];                            // [R2]
      end else if (ch.match) begin
        case (low2)
          `TBCIO_ACT_LOW:  s_next.lvl = 1'b0;                           // [R1]
          `TBCIO_ACT_HIGH: s_next.lvl = 1'b1;                           // [R1]
          `TBCIO_ACT_TGL:  s_next.lvl = !s_reg.lvl;                     // [R1]
          default:         s_next.lvl = s_reg.lvl;
        endcase
      end
    end else begin
      s_next.cap = int_src ? ch.int_event : pin_hit;                    // [R4] [R5] [R6] [R7]
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign ch.pin_out = s_reg.lvl;
  assign ch.pin_oe  = cmp_en;                                           // [R1]
  assign ch.cap     = s_reg.cap;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_match_low: assert property (!ch.load && !is_cap && low2 == `TBCIO_ACT_LOW && ch.match // [R1]
    |=> !ch.pin_out) else $error("low action did not drive low");
  chk_match_high: assert property (!ch.load && !is_cap && low2 == `TBCIO_ACT_HIGH // [R1]
    && ch.match |=> ch.pin_out) else $error("high action did not drive high");
  chk_match_toggle: assert property (!ch.load && !is_cap && low2 == `TBCIO_ACT_TGL // [R1]
    && ch.match |=> ch.pin_out != $past(ch.pin_out)) else $error("toggle action missed");
  chk_init_level: assert property (ch.load && cmp_en // [R2]
    |=> ch.pin_out == $past(ch.field[`TBCIO_F_SRC])) else $error("initial level wrong");
  chk_rise_cap: assert property (is_cap && !int_src && low2 == `TBCIO_EDGE_RISE && rise // [R3] [R4]
    |=> ch.cap) else $error("rising edge not captured");
  chk_fall_only: assert property (is_cap && !int_src && low2 == `TBCIO_EDGE_FALL && rise // [R3]
    |=> !ch.cap) else $error("rising edge captured in falling mode");
  chk_both_edges: assert property (is_cap && !int_src && ch.field[`TBCIO_F_BOTH] // [R3]
    && (rise || fall) |=> ch.cap) else $error("edge missed in both-edge mode");
  chk_int_cap: assert property (is_cap && int_src && ch.int_event ##1 1'b1 // [R5] [R6]
    |-> ch.cap) else $error("internal event not captured");
  chk_pin_ignored: assert property (is_cap && int_src && !ch.int_event // [R5]
    |=> !ch.cap) else $error("pin edge captured with internal source");
  chk_no_drive_cap: assert property (is_cap |-> !ch.pin_oe) // [R3]
    else $error("pin driven in capture mode");

  cov_toggle: cover property (!is_cap && low2 == `TBCIO_ACT_TGL && ch.match);
  cov_pin_cap: cover property (is_cap && !int_src ##1 ch.cap);
  cov_int_cap: cover property (is_cap && int_src ##1 ch.cap);

endmodule // tbcio_chan

//--- rtl/tbcio_chan_if.sv
// signals between the register file and one channel's pin logic
interface tbcio_chan_if;
  logic [3:0] field;      // b field of the i/o control register
  logic       load;       // field was written last cycle
  logic       match;      // compare match of the b general register
  logic       int_event;  // internal capture source event
  logic       pin_in;     // b pin level
  logic       pin_out;    // b pin drive level
  logic       pin_oe;     // b pin drive enable
  logic       cap;        // capture into the b general register

  modport regs (output field, load, match, int_event, pin_in,
                input  pin_out, pin_oe, cap);
  modport chan (input  field, load, match, int_event, pin_in,
                output pin_out, pin_oe, cap);
endinterface : tbcio_chan_if

//--- rtl/tbcio_consts.svh
// constants of the channel b i/o control block
`ifndef TBCIO_CONSTS_SVH
`define TBCIO_CONSTS_SVH

// register offsets on the plain register port
`define TBCIO_OFS_CH1      3'h0
`define TBCIO_OFS_CH2      3'h1
`define TBCIO_OFS_CH3      3'h2
`define TBCIO_OFS_STAT     3'h3

// reset values
`define TBCIO_IO_RST       8'h00
`define TBCIO_FIELD_RST    4'h0
`define TBCIO_STAT_RST     3'h0
`define TBCIO_BYTE_ZERO    8'h00

// position of the b field inside each i/o control register, and top bit of the status flags
`define TBCIO_B_HI         7
`define TBCIO_B_LO         4
`define TBCIO_STAT_HI      2

// bits inside the four-bit b field
`define TBCIO_F_CAP        3
`define TBCIO_F_SRC        2
`define TBCIO_F_BOTH       1
`define TBCIO_F_FALL       0

// compare match actions in the two low field bits
`define TBCIO_ACT_OFF      2'h0
`define TBCIO_ACT_LOW      2'h1
`define TBCIO_ACT_HIGH     2'h2
`define TBCIO_ACT_TGL      2'h3

// capture edge codes in the two low field bits
`define TBCIO_EDGE_RISE    2'h0
`define TBCIO_EDGE_FALL    2'h1

// prescaler code that feeds channel 4 with the undivided clock
`define TBCIO_PSC_UNDIV    3'h0

`endif

//--- rtl/tbcio_pkg.sv
// types of the channel b i/o control block
package tbcio_pkg;

  // state of one channel's pin and capture logic
  typedef struct packed {
    logic lvl;       // level driven on the b pin
    logic pin_prev;  // pin sample of the last cycle
    logic cap;       // capture strobe
  } tbcio_chan_state_t;

  // state of the register file
  typedef struct packed {
    logic [2:0][7:0] io;      // i/o control registers of channels 1..3
    logic [2:0]      ld;      // field written last cycle
    logic [2:0]      stat;    // sticky capture flags
    logic [7:0]      rdata;   // read data
  } tbcio_top_state_t;

endpackage : tbcio_pkg

//--- rtl/tbcio_top.sv
// register file and channel wiring of the channel b i/o control block
//
// Contract
// R1: top field bit 0 selects compare; low bits pick off, low, high, toggle.
// R2: compare with output enabled sets initial pin level from field bit two.
// R3: top field bit 1 selects capture; low bits pick rising, falling, both edges.
// R4: channels 1 and 3 with field 10xx capture from their own b pin.
// R5: channel 1 with field 11xx captures on channel 0 c register event.
// R6: channel 3 with field 11xx captures on each channel 4 count.
// R7: channel 2 ignores field bit two; capture always from its own pin.
// R8: channel 3 internal capture is dead when channel 4 prescaler is 000.
// R9: after reset every field is 0000: compare with output disabled.
//
// Local design decisions: strobed register access and the address map.
`include "tbcio_consts.svh"

module tbcio_top (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic [2:0] b_match,
  input  wire logic       chan0_c_event,
  input  wire logic       chan4_count_pulse,
  input  wire logic [2:0] prescale_select,
  input  wire logic [2:0] b_pin_in,
  output logic      [2:0] b_pin_out,
  output logic      [2:0] b_pin_oe,
  output logic      [2:0] b_capture
);

  tbcio_pkg::tbcio_top_state_t s_reg;
  tbcio_pkg::tbcio_top_state_t s_next;

  logic [2:0] wr_io;
  logic [2:0] int_ev;
  logic [2:0] cap;
  logic [2:0] pin_out;
  logic [2:0] pin_oe;
  logic [2:0][3:0] fld;      // b field per channel, for the checks
  logic [2:0][1:0] fld_act;  // two low field bits per channel

  // write decode per i/o control register
  assign wr_io[0] = wr && (addr == `TBCIO_OFS_CH1);
  assign wr_io[1] = wr && (addr == `TBCIO_OFS_CH2);
  assign wr_io[2] = wr && (addr == `TBCIO_OFS_CH3);

  // internal capture sources per channel
  assign int_ev[0] = chan0_c_event;                                     // [R5]
  assign int_ev[1] = 1'b0;                                              // [R7]
  assign int_ev[2] = chan4_count_pulse
                     && (prescale_select != `TBCIO_PSC_UNDIV);          // [R6] [R8]

  // register file next state
  always_comb begin
    s_next       = s_reg;
    s_next.ld    = wr_io;
    s_next.rdata = `TBCIO_BYTE_ZERO;
    for (int i = 0; i < 3; i++) begin
      if (wr_io[i]) begin
        s_next.io[i] = wdata;
      end
    end
    // sticky capture flags: write one clears, a new capture wins
    if (wr && (addr == `TBCIO_OFS_STAT)) begin
      s_next.stat = s_reg.stat & ~wdata[`TBCIO_STAT_HI:0];
    end
    s_next.stat = s_next.stat | cap;
    if (rd) begin
      case (addr)
        `TBCIO_OFS_CH1:  s_next.rdata = s_reg.io[0];
        `TBCIO_OFS_CH2:  s_next.rdata = s_reg.io[1];
        `TBCIO_OFS_CH3:  s_next.rdata = s_reg.io[2];
        `TBCIO_OFS_STAT: s_next.rdata = {5'h00, s_reg.stat};
        default:         s_next.rdata = `TBCIO_BYTE_ZERO;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_reg.io    <= {3{`TBCIO_IO_RST}};                                // [R9]
      s_reg.ld    <= 3'h0;
      s_reg.stat  <= `TBCIO_STAT_RST;
      s_reg.rdata <= `TBCIO_BYTE_ZERO;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata     = s_reg.rdata;
  assign b_pin_out = pin_out;
  assign b_pin_oe  = pin_oe;
  assign b_capture = cap;

  // b fields and their two low bits, as the checks see them
  assign fld[0]     = s_reg.io[0][`TBCIO_B_HI:`TBCIO_B_LO];
  assign fld[1]     = s_reg.io[1][`TBCIO_B_HI:`TBCIO_B_LO];
  assign fld[2]     = s_reg.io[2][`TBCIO_B_HI:`TBCIO_B_LO];
  assign fld_act[0] = fld[0][`TBCIO_F_BOTH:`TBCIO_F_FALL];
  assign fld_act[1] = fld[1][`TBCIO_F_BOTH:`TBCIO_F_FALL];
  assign fld_act[2] = fld[2][`TBCIO_F_BOTH:`TBCIO_F_FALL];

  // one pin and capture unit per channel 1..3
  for (genvar g = 0; g < 3; g++) begin : g_chan
    tbcio_chan_if chif ();

    assign chif.field     = s_reg.io[g][`TBCIO_B_HI:`TBCIO_B_LO];
    assign chif.load      = s_reg.ld[g];
    assign chif.match     = b_match[g];
    assign chif.int_event = int_ev[g];
    assign chif.pin_in    = b_pin_in[g];
    assign pin_out[g]     = chif.pin_out;
    assign pin_oe[g]      = chif.pin_oe;
    assign cap[g]         = chif.cap;

    tbcio_chan #(
      .CHAN  (g + 1)
    ) u_chan (
      .clk   (clk),
      .rst_b (rst_b),
      .ch    (chif.chan)
    );
  end

  // checks
  default clocking cb @(posedge clk); endclocking

  chk_reset_field: assert property (!rst_b |=> // [R9]
    s_reg.io[0][`TBCIO_B_HI:`TBCIO_B_LO] == `TBCIO_FIELD_RST
    && s_reg.io[1][`TBCIO_B_HI:`TBCIO_B_LO] == `TBCIO_FIELD_RST
    && s_reg.io[2][`TBCIO_B_HI:`TBCIO_B_LO] == `TBCIO_FIELD_RST)
    else $error("field not cleared by reset");
  chk_reset_no_drive: assert property (disable iff (!rst_b) // [R9]
    $past(!rst_b) |-> b_pin_oe == 3'h0) else $error("pin driven after reset");
  chk_psc_block: assert property (disable iff (!rst_b) // [R8]
    fld[2][`TBCIO_F_CAP] && fld[2][`TBCIO_F_SRC] && !b_pin_in[2] && !$past(b_pin_in[2])
    && prescale_select == `TBCIO_PSC_UNDIV |=> !b_capture[2])
    else $error("channel 3 captured with undivided clock");
  chk_ch2_pin_only: assert property (disable iff (!rst_b) // [R7]
    s_reg.io[1][`TBCIO_B_HI] && b_pin_in[1] == $past(b_pin_in[1]) |=> !b_capture[1])
    else $error("channel 2 captured without a pin edge");
  chk_sticky_set: assert property (disable iff (!rst_b)
    b_capture[0] |=> s_reg.stat[0]) else $error("capture flag lost");
  chk_read_latency: assert property (disable iff (!rst_b)
    rd && addr == `TBCIO_OFS_CH2 |=> rdata == $past(s_reg.io[1]))
    else $error("read data wrong");

  // pin drive enable, match action and initial level seen at the pins
  chk_oe_decode: assert property (disable iff (!rst_b) // [R1]
    b_pin_oe[0] == (!fld[0][`TBCIO_F_CAP] && fld_act[0] != `TBCIO_ACT_OFF)
    && b_pin_oe[1] == (!fld[1][`TBCIO_F_CAP] && fld_act[1] != `TBCIO_ACT_OFF)
    && b_pin_oe[2] == (!fld[2][`TBCIO_F_CAP] && fld_act[2] != `TBCIO_ACT_OFF))
    else $error("pin drive enable does not follow the field");
  chk_ch3_match_high: assert property (disable iff (!rst_b) // [R1]
    !fld[2][`TBCIO_F_CAP] && fld_act[2] == `TBCIO_ACT_HIGH && b_match[2] && !s_reg.ld[2]
    |=> b_pin_out[2]) else $error("channel 3 high action missed");
  chk_ch2_init_level: assert property (disable iff (!rst_b) // [R2]
    s_reg.ld[1] && b_pin_oe[1] |=> b_pin_out[1] == $past(fld[1][`TBCIO_F_SRC]))
    else $error("channel 2 initial level wrong");

  // pin-fed capture of channels 1..3
  chk_ch1_pin_rise: assert property (disable iff (!rst_b) // [R4]
    fld[0][`TBCIO_F_CAP] && !fld[0][`TBCIO_F_SRC] && fld_act[0] == `TBCIO_EDGE_RISE
    && b_pin_in[0] && !$past(b_pin_in[0]) |=> b_capture[0])
    else $error("channel 1 rising pin edge not captured");
  chk_ch1_fall_only: assert property (disable iff (!rst_b) // [R3]
    fld[0][`TBCIO_F_CAP] && !fld[0][`TBCIO_F_SRC] && fld_act[0] == `TBCIO_EDGE_FALL
    && b_pin_in[0] && !$past(b_pin_in[0]) |=> !b_capture[0])
    else $error("channel 1 captured a rising edge in falling mode");
  chk_ch1_pin_both: assert property (disable iff (!rst_b) // [R3]
    fld[0][`TBCIO_F_CAP] && !fld[0][`TBCIO_F_SRC] && fld[0][`TBCIO_F_BOTH]
    && b_pin_in[0] != $past(b_pin_in[0]) |=> b_capture[0])
    else $error("channel 1 pin edge missed in both-edge mode");
  chk_ch3_pin_fall: assert property (disable iff (!rst_b) // [R4]
    fld[2][`TBCIO_F_CAP] && !fld[2][`TBCIO_F_SRC] && fld_act[2] == `TBCIO_EDGE_FALL
    && !b_pin_in[2] && $past(b_pin_in[2]) |=> b_capture[2])
    else $error("channel 3 falling pin edge not captured");
  chk_ch3_rise_only: assert property (disable iff (!rst_b) // [R3]
    fld[2][`TBCIO_F_CAP] && !fld[2][`TBCIO_F_SRC] && fld_act[2] == `TBCIO_EDGE_RISE
    && !b_pin_in[2] && $past(b_pin_in[2]) |=> !b_capture[2])
    else $error("channel 3 captured a falling edge in rising mode");
  chk_ch2_src_ignored: assert property (disable iff (!rst_b) // [R7]
    fld[1][`TBCIO_F_CAP] && fld[1][`TBCIO_F_SRC] && fld_act[1] == `TBCIO_EDGE_RISE
    && b_pin_in[1] && !$past(b_pin_in[1]) |=> b_capture[1])
    else $error("channel 2 pin edge lost with field bit two set");
  chk_ch2_both_src: assert property (disable iff (!rst_b) // [R7]
    fld[1][`TBCIO_F_CAP] && fld[1][`TBCIO_F_SRC] && fld[1][`TBCIO_F_BOTH]
    && b_pin_in[1] != $past(b_pin_in[1]) |=> b_capture[1])
    else $error("channel 2 both-edge capture lost with field bit two set");

  // internal capture sources
  chk_ch1_int_cap: assert property (disable iff (!rst_b) // [R5]
    fld[0][`TBCIO_F_CAP] && fld[0][`TBCIO_F_SRC] && chan0_c_event |=> b_capture[0])
    else $error("channel 0 c event not captured");
  chk_ch1_int_only: assert property (disable iff (!rst_b) // [R5]
    fld[0][`TBCIO_F_CAP] && fld[0][`TBCIO_F_SRC] && !chan0_c_event |=> !b_capture[0])
    else $error("channel 1 captured without a channel 0 c event");
  chk_ch3_count_cap: assert property (disable iff (!rst_b) // [R6]
    fld[2][`TBCIO_F_CAP] && fld[2][`TBCIO_F_SRC] && chan4_count_pulse
    && prescale_select != `TBCIO_PSC_UNDIV |=> b_capture[2])
    else $error("channel 4 count not captured");
  chk_ch3_count_only: assert property (disable iff (!rst_b) // [R6]
    fld[2][`TBCIO_F_CAP] && fld[2][`TBCIO_F_SRC] && !chan4_count_pulse |=> !b_capture[2])
    else $error("channel 3 captured without a channel 4 count");

  // reset and register port
  chk_reset_outputs: assert property (!rst_b |=> // [R9]
    rdata == `TBCIO_BYTE_ZERO && b_capture == '0 && b_pin_oe == '0)
    else $error("outputs not cleared by reset");
  chk_rdata_idle: assert property (disable iff (!rst_b)
    !rd |=> rdata == `TBCIO_BYTE_ZERO)
    else $error("read data outside a read cycle");
  chk_read_status: assert property (disable iff (!rst_b)
    rd && addr == `TBCIO_OFS_STAT |=> rdata == {5'h00, $past(s_reg.stat)})
    else $error("status read data wrong");
  chk_flag_clear: assert property (disable iff (!rst_b)
    wr && addr == `TBCIO_OFS_STAT && wdata[0] && !b_capture[0] |=> !s_reg.stat[0])
    else $error("capture flag not cleared");
  chk_write_lands: assert property (disable iff (!rst_b)
    wr && addr == `TBCIO_OFS_CH3 |=> s_reg.io[2] == $past(wdata))
    else $error("write to channel 3 register lost");
  chk_unmapped_write: assert property (disable iff (!rst_b)
    wr && addr > `TBCIO_OFS_STAT |=> s_reg.io == $past(s_reg.io))
    else $error("unmapped write changed a register");

  cov_write_field: cover property (disable iff (!rst_b) wr_io[2] ##1 s_reg.ld[2]);
  cov_flag_clear: cover property (disable iff (!rst_b)
    wr && addr == `TBCIO_OFS_STAT && b_capture[0]);

endmodule // tbcio_top

//--- sim/tbcio_pin_model.sv
// far-side model of the three b pins: device drive or external source
module tbcio_pin_model (
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe,
  input  wire logic [2:0] ext_lvl,
  output logic      [2:0] pin_in
);
  timeunit 1ns;
  timeprecision 100ps;

  // wire level: device drive wins, otherwise the external source
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_lvl[i];
    end
  end
endmodule // tbcio_pin_model

//--- sim/timer_b_channel_io_control_tb_top.sv
// self-checking bench of the channel b i/o control block
`include "tbcio_consts.svh"

module timer_b_channel_io_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk;
  logic       rst_b;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic [2:0] b_match;
  logic       chan0_c_event;
  logic       chan4_count_pulse;
  logic [2:0] prescale_select;
  logic [2:0] ext_lvl;
  logic [2:0] b_pin_in;
  logic [2:0] b_pin_out;
  logic [2:0] b_pin_oe;
  logic [2:0] b_capture;
  int         error_cnt;
  int         compares;

  tbcio_top dut_u (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .b_match(b_match), .chan0_c_event(chan0_c_event),
    .chan4_count_pulse(chan4_count_pulse), .prescale_select(prescale_select),
    .b_pin_in(b_pin_in), .b_pin_out(b_pin_out), .b_pin_oe(b_pin_oe), .b_capture(b_capture));

  tbcio_pin_model pin_u (.pin_out(b_pin_out), .pin_oe(b_pin_oe), .ext_lvl(ext_lvl),
    .pin_in(b_pin_in));

  // clock generation
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // one comparison, counted
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one-cycle register write
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // one-cycle register read, data taken in the following cycle
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // move the external pin levels, then judge the capture strobes
  task automatic pin_set(input logic [2:0] lvl, input logic [2:0] exp);
    @(posedge clk);
    ext_lvl <= lvl;
    @(posedge clk);
    #1;
    check({5'h00, b_capture}, {5'h00, exp});
  endtask

  // one-cycle internal event pulse, then judge the capture strobes
  task automatic ev_pulse(input logic [1:0] ev, input logic [2:0] psc, input logic [2:0] exp);
    @(posedge clk);
    chan0_c_event <= ev[0];
    chan4_count_pulse <= ev[1];
    prescale_select <= psc;
    @(posedge clk);
    chan0_c_event <= 1'b0;
    chan4_count_pulse <= 1'b0;
    #1;
    check({5'h00, b_capture}, {5'h00, exp});
  endtask

  // reset values, unmapped address
  task automatic test_reset();
    logic [7:0] d;
    check({5'h00, b_pin_oe}, `TBCIO_BYTE_ZERO);
    for (int a = 0; a < 8; a++) begin
      reg_rd(a[2:0], d);
      check(d, `TBCIO_BYTE_ZERO);
    end
    reg_wr(3'h5, 8'hFF);
    reg_rd(3'h5, d);
    check(d, `TBCIO_BYTE_ZERO);
    $display("test reset done");
  endtask

  // every compare setting on every channel: enable, initial level, match action
  task automatic test_compare();
    logic [3:0] f;
    logic       exp;
    for (int c = 0; c < 3; c++) begin
      for (int i = 0; i < 8; i++) begin
        f = i[3:0];
        reg_wr(c[2:0], {f, 4'h0});
        @(posedge clk);
        #1;
        check({7'h00, b_pin_oe[c]}, {7'h00, f[1:0] != `TBCIO_ACT_OFF});
        if (f[1:0] != `TBCIO_ACT_OFF)
          check({7'h00, b_pin_out[c]}, {7'h00, f[2]});
        exp = (f[1:0] == `TBCIO_ACT_TGL) ? ~f[2] : f[1];
        @(posedge clk);
        b_match <= 3'h1 << c;
        @(posedge clk);
        b_match <= 3'h0;
        #1;
        if (f[1:0] != `TBCIO_ACT_OFF)
          check({7'h00, b_pin_out[c]}, {7'h00, exp});
        else
          check({7'h00, b_pin_oe[c]}, 8'h00);
      end
    end
    $display("test compare done");
  endtask

  // pin-fed capture on every edge code; channel 2 also with bit two set
  task automatic test_capture_pin();
    logic [3:0] f;
    logic [2:0] m;
    for (int c = 0; c < 3; c++) begin
      m = 3'h1 << c;
      for (int i = 8; i < 16; i++) begin
        f = i[3:0];
        if (f[2] && c != 1)
          continue;
        reg_wr(c[2:0], {f, 4'h0});
        repeat (3) @(posedge clk);
        pin_set(m, (f[1:0] != `TBCIO_EDGE_FALL) ? m : 3'h0);
        pin_set(3'h0, (f[1:0] != `TBCIO_EDGE_RISE) ? m : 3'h0);
      end
    end
    $display("test capture pin done");
  endtask

  // internal capture sources of channels 1 and 3
  task automatic test_capture_int();
    logic [7:0] d;
    reg_wr(`TBCIO_OFS_CH1, 8'hC0);
    reg_wr(`TBCIO_OFS_CH3, 8'hC0);
    ev_pulse(2'h0, 3'h1, 3'h0);
    repeat (2) @(posedge clk);
    ev_pulse(2'h1, 3'h1, 3'h1);
    ev_pulse(2'h2, 3'h1, 3'h4);
    ev_pulse(2'h3, 3'h2, 3'h5);
    pin_set(3'h5, 3'h0);
    pin_set(3'h0, 3'h0);
    ev_pulse(2'h2, `TBCIO_PSC_UNDIV, 3'h0);
    ev_pulse(2'h3, `TBCIO_PSC_UNDIV, 3'h1);
    reg_rd(`TBCIO_OFS_STAT, d);
    check(d, 8'h07);
    reg_wr(`TBCIO_OFS_STAT, 8'h07);
    reg_rd(`TBCIO_OFS_STAT, d);
    check(d, 8'h00);
    reg_rd(`TBCIO_OFS_CH1, d);
    check(d, 8'hC0);
    reg_rd(`TBCIO_OFS_CH2, d);
    check(d, 8'hF0);
    reg_rd(`TBCIO_OFS_CH3, d);
    check(d, 8'hC0);
    $display("test capture internal done");
  endtask

  // verdict and end of run
  task automatic results();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // main sequence
  initial begin
    rst_b = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    b_match = 3'h0;
    chan0_c_event = 1'b0;
    chan4_count_pulse = 1'b0;
    prescale_select = 3'h0;
    ext_lvl = 3'h0;
    error_cnt = 0;
    compares = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    test_reset();
    test_compare();
    test_capture_pin();
    test_capture_int();
    results();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    $display("watchdog expired");
    error_cnt++;
    results();
  end
endmodule // timer_b_channel_io_control_tb_top
